// [logic/iru_uart.sv]
// Purpose: register-mapped infrared serial port with queued rx and tx
// Assumes: Avalon-MM slave, byte addresses, one clock, sync reset
// Notes: counts above 255 read back as 255 in the 8-bit fields
// Functional notes
// - frames are 8 data bits, one stop bit, no parity, 115200 baud
// - received characters wait in a 256-entry queue until read
// - receive fill count appears in data register bits 23..16
// - a character arriving to a full receive queue is discarded
// - data register bit 15 is high while a character is queued
// - data read returns oldest character, pops it, count already decremented
// - empty queue reads valid flag zero, character bits zero
// - writes to data bits 7..0 fill a separate 256-entry transmit queue
// - data writes never touch the receive queue, count or valid flag
// - transmit free space appears in control register bits 23..16
// - data writes to a full transmit queue are dropped and set the status drop flag
// - enabled interrupt when fill count or free space exceeds 31
// - two pending flags in control follow the counts against threshold

`timescale 1ns/10ps

module iru_uart
    import iru_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int BIT_CYCLES = BIT_CYC
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ir_rxd,
    output logic ir_txd,
    output logic irq
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int TW = $clog2(BIT_CYCLES + 1);
    localparam logic [TW-1:0] BIT_RLD = TW'(BIT_CYCLES - 1);
    localparam logic [TW-1:0] HALF_RLD = TW'(BIT_CYCLES / 2 - 1);

    if (BIT_CYCLES < 16 || DEPTH > FIFO_DEPTH)
    begin : g_bad_param
        $error("iru_uart: BIT_CYCLES below 16 or DEPTH above 256");
    end

    function automatic logic [7:0] sat8(input int v);
        sat8 = (v > 255) ? 8'hFF : 8'(v);
    endfunction

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic ack_q;
    logic take;
    logic sel_data;
    logic sel_ctrl;
    logic sel_stat;
    logic sel_mask;
    logic [31:0] rdata_q;

    // one wait state: the answer is set up on the edge that takes it
    assign take = (avs_read | avs_write) & ~ack_q;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign avs_readdata = rdata_q;
    assign sel_data = avs_address == DATA_OFS;
    assign sel_ctrl = avs_address == CTRL_OFS;
    assign sel_stat = avs_address == STAT_OFS;
    assign sel_mask = avs_address == MASK_OFS;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= take;
        end
    end

    // ----------------------------------------
    // queues
    // ----------------------------------------
    logic rx_push_q;
    logic rx_push_ready;
    logic [CHAR_W-1:0] rx_byte_q;
    logic rx_valid;
    logic rx_pop;
    logic [CHAR_W-1:0] rx_head;
    logic [CW-1:0] rx_fill_count;
    logic tx_push;
    logic tx_push_ready;
    logic tx_valid;
    logic tx_pop;
    logic [CHAR_W-1:0] tx_head;
    logic [CW-1:0] tx_cnt;
    logic [CW-1:0] tx_free_space;
    logic rx_irq_pending;
    logic tx_irq_pending;

    assign rx_pop = take & avs_read & sel_data;
    assign tx_push = take & avs_write & sel_data & avs_byteenable[0];
    assign tx_free_space = CW'(DEPTH) - tx_cnt;
    assign rx_irq_pending = int'(rx_fill_count) > IRQ_THRESH;
    assign tx_irq_pending = int'(tx_free_space) > IRQ_THRESH;

    // full queue refuses the push, so the stored contents stay put
    iru_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) u_rx_fifo (
        .mclk(mclk),
        .rst(rst),
        .push_valid(rx_push_q),
        .push_ready(rx_push_ready),
        .push_data(rx_byte_q),
        .pop_valid(rx_valid),
        .pop_ready(rx_pop),
        .pop_data(rx_head),
        .count(rx_fill_count)
    );

    iru_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) u_tx_fifo (
        .mclk(mclk),
        .rst(rst),
        .push_valid(tx_push),
        .push_ready(tx_push_ready),
        .push_data(avs_writedata[CHAR_W-1:0]),
        .pop_valid(tx_valid),
        .pop_ready(tx_pop),
        .pop_data(tx_head),
        .count(tx_cnt)
    );

    // ----------------------------------------
    // control, status and interrupt
    // ----------------------------------------
    logic [1:0] ctrl_q;
    logic [EV_W-1:0] stat_q;
    logic [EV_W-1:0] mask_q;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] w1c;
    logic frame_err_q;

    assign ev[EV_RX_OVER] = rx_push_q & ~rx_push_ready;
    assign ev[EV_TX_DROP] = tx_push & ~tx_push_ready;
    assign ev[EV_FRAME] = frame_err_q;
    assign w1c = (take & avs_write & sel_stat & avs_byteenable[0])
        ? avs_writedata[EV_W-1:0] : '0;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_q <= CTRL_RST;
            mask_q <= EV_RST;
        end
        else if (take && avs_write && avs_byteenable[0])
        begin
            if (sel_ctrl)
            begin
                ctrl_q <= avs_writedata[1:0];
            end
            if (sel_mask)
            begin
                mask_q <= avs_writedata[EV_W-1:0];
            end
        end
    end

    // new event wins over a clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            stat_q <= EV_RST;
        end
        else
        begin
            stat_q <= (stat_q & ~w1c) | ev;
        end
    end

    assign irq = (rx_irq_pending & ctrl_q[RX_IE_BIT])
        | (tx_irq_pending & ctrl_q[TX_IE_BIT])
        | (|(stat_q & mask_q));

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdata_q <= '0;
        end
        else if (take && avs_read)
        begin
            rdata_q <= '0;
            if (sel_data)
            begin
                // count already reflects this pop
                rdata_q[CNT_LSB+:8] <= sat8(int'(rx_fill_count) - int'(rx_valid));
                rdata_q[VALID_BIT] <= rx_valid;
                rdata_q[CHAR_W-1:0] <= rx_valid ? rx_head : 8'h00;
            end
            else if (sel_ctrl)
            begin
                rdata_q[CNT_LSB+:8] <= sat8(int'(tx_free_space));
                rdata_q[RX_PEND_BIT] <= rx_irq_pending;
                rdata_q[TX_PEND_BIT] <= tx_irq_pending;
                rdata_q[1:0] <= ctrl_q;
            end
            else if (sel_stat)
            begin
                rdata_q[EV_W-1:0] <= stat_q;
            end
            else if (sel_mask)
            begin
                rdata_q[EV_W-1:0] <= mask_q;
            end
        end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    logic [2:0] rxd_sync_q;
    logic rxd;
    logic rxd_last;
    iru_rx_st_t rx_st_q;
    logic [TW-1:0] rx_tmr_q;
    logic [2:0] rx_bit_q;
    logic [CHAR_W-1:0] rx_sh_q;

    assign rxd = rxd_sync_q[1];
    // start needs a high-to-low edge, so a low stop bit is not taken as a new start
    assign rxd_last = rxd_sync_q[2];

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rxd_sync_q <= 3'h7;
        end
        else
        begin
            rxd_sync_q <= {rxd_sync_q[1:0], ir_rxd};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rx_st_q <= RX_IDLE;
            rx_tmr_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q <= '0;
            rx_byte_q <= '0;
            rx_push_q <= 1'b0;
            frame_err_q <= 1'b0;
        end
        else
        begin
            rx_push_q <= 1'b0;
            frame_err_q <= 1'b0;
            if (rx_tmr_q != '0)
            begin
                rx_tmr_q <= rx_tmr_q - 1'b1;
            end
            case (rx_st_q)
                RX_IDLE:
                begin
                    if (rxd_last && !rxd)
                    begin
                        rx_tmr_q <= HALF_RLD;
                        rx_st_q <= RX_START;
                    end
                end
                RX_START:
                begin
                    if (rx_tmr_q == '0)
                    begin
                        rx_tmr_q <= BIT_RLD;
                        rx_bit_q <= '0;
                        rx_st_q <= rxd ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    if (rx_tmr_q == '0)
                    begin
                        rx_sh_q <= {rxd, rx_sh_q[CHAR_W-1:1]};
                        rx_tmr_q <= BIT_RLD;
                        rx_bit_q <= rx_bit_q + 1'b1;
                        if (rx_bit_q == 3'h7)
                        begin
                            rx_st_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP:
                begin
                    if (rx_tmr_q == '0)
                    begin
                        rx_byte_q <= rx_sh_q;
                        rx_push_q <= rxd;
                        frame_err_q <= ~rxd;
                        rx_st_q <= RX_IDLE;
                    end
                end
                default:
                begin
                    rx_st_q <= RX_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    logic [TW-1:0] div_q;
    logic baud_tick;
    iru_tx_st_t tx_st_q;
    logic [CHAR_W:0] tx_sh_q;
    logic [3:0] tx_n_q;
    logic txd_q;

    assign baud_tick = div_q == '0;
    assign tx_pop = (tx_st_q == TX_IDLE) & baud_tick & tx_valid;
    assign ir_txd = txd_q;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            div_q <= BIT_RLD;
        end
        else
        begin
            div_q <= baud_tick ? BIT_RLD : div_q - 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tx_st_q <= TX_IDLE;
            tx_sh_q <= '1;
            tx_n_q <= '0;
            txd_q <= 1'b1;
        end
        else if (baud_tick)
        begin
            case (tx_st_q)
                TX_IDLE:
                begin
                    if (tx_valid)
                    begin
                        txd_q <= 1'b0;
                        tx_sh_q <= {1'b1, tx_head};
                        tx_n_q <= 4'(FRAME_BITS - 1);
                        tx_st_q <= TX_SHIFT;
                    end
                end
                TX_SHIFT:
                begin
                    if (tx_n_q == 4'h0)
                    begin
                        tx_st_q <= TX_IDLE;
                    end
                    else
                    begin
                        txd_q <= tx_sh_q[0];
                        tx_sh_q <= {1'b1, tx_sh_q[CHAR_W:1]};
                        tx_n_q <= tx_n_q - 1'b1;
                    end
                end
                default:
                begin
                    tx_st_q <= TX_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("answer not after one wait");
    a_empty_read_flag: assert property (take && avs_read && sel_data && !rx_valid
        |=> !avs_readdata[VALID_BIT]) else $error("valid set on empty read");
    a_pop_count_dec: assert property (take && avs_read && sel_data && rx_valid
        |=> int'(avs_readdata[CNT_LSB+:8]) == int'($past(rx_fill_count)) - 1
        && avs_readdata[VALID_BIT]) else $error("fill count not decremented");
    a_rx_full_drop: assert property (rx_push_q && !rx_push_ready && !rx_pop
        |=> rx_fill_count == $past(rx_fill_count)) else $error("full rx queue changed");
    a_write_no_rx: assert property (tx_push && !rx_push_q
        |=> rx_fill_count == $past(rx_fill_count)) else $error("write disturbed rx queue");
    a_tx_full_drop: assert property (tx_push && !tx_push_ready && !tx_pop
        |=> tx_cnt == $past(tx_cnt)) else $error("full tx queue accepted a char");
    a_free_read: assert property (take && avs_read && sel_ctrl
        |=> int'(avs_readdata[CNT_LSB+:8]) == int'(sat8(int'($past(tx_free_space))))
        && avs_readdata[RX_PEND_BIT] == ($past(rx_fill_count) > 31))
        else $error("control read wrong");
    a_start_bit_low: assert property ($fell(ir_txd) |=> !ir_txd [*8])
        else $error("start bit too short");
    a_irq_enable: assert property (rx_irq_pending && ctrl_q[RX_IE_BIT] |-> irq)
        else $error("irq missing for rx threshold");
    a_over_sticky: assert property (ev[EV_RX_OVER] |=> stat_q[EV_RX_OVER])
        else $error("overflow not recorded");

    c_rx_char: cover property (rx_push_q && rx_push_ready);
    c_tx_frame: cover property ($fell(ir_txd));
    c_irq_rise: cover property ($rose(irq));

endmodule

// [logic/iru_pkg.sv]
// Purpose: shared constants for the infrared serial port
// Assumes: 125 MHz mclk, byte addresses on the register bus
// Notes: one aligned 32-bit word per register

package iru_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [31:0] DATA_OFS = 32'hFF20_1020;
    localparam logic [31:0] CTRL_OFS = 32'hFF20_1024;
    localparam logic [31:0] STAT_OFS = 32'hFF20_1028;
    localparam logic [31:0] MASK_OFS = 32'hFF20_102C;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CHAR_W = 8;
    localparam int CNT_LSB = 16;
    localparam int VALID_BIT = 15;
    localparam int RX_IE_BIT = 0;
    localparam int TX_IE_BIT = 1;
    localparam int RX_PEND_BIT = 8;
    localparam int TX_PEND_BIT = 9;

    // ----------------------------------------
    // sticky events
    // ----------------------------------------
    localparam int EV_W = 3;
    localparam int EV_RX_OVER = 0;
    localparam int EV_TX_DROP = 1;
    localparam int EV_FRAME = 2;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [EV_W-1:0] EV_RST = 3'h0;

    // ----------------------------------------
    // sizes and timing
    // ----------------------------------------
    localparam int FIFO_DEPTH = 256;
    localparam int IRQ_THRESH = 31;
    localparam int CLK_HZ = 125_000_000;
    localparam int BAUD_RATE = 115_200;
    localparam int BIT_CYC = CLK_HZ / BAUD_RATE;
    localparam int FRAME_BITS = 10;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} iru_rx_st_t;
    typedef enum logic {TX_IDLE, TX_SHIFT} iru_tx_st_t;

endpackage

// [logic/iru_fifo.sv]
// Purpose: synchronous first-in first-out character store
// Assumes: single clock, synchronous active-high reset
// Notes: head word is visible on pop_data while pop_valid is high

`timescale 1ns/10ps

module iru_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int CW = $clog2(DEPTH + 1)
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic push_valid,
    output logic push_ready,
    input wire logic [WIDTH-1:0] push_data,
    output logic pop_valid,
    input wire logic pop_ready,
    output logic [WIDTH-1:0] pop_data,
    output logic [CW-1:0] count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic do_push;
    logic do_pop;

    if (DEPTH < 2 || CW != $clog2(DEPTH + 1))
    begin : g_bad_depth
        $error("iru_fifo: DEPTH must be at least 2 and CW left at default");
    end

    assign push_ready = cnt_q != CW'(DEPTH);
    assign pop_valid = cnt_q != '0;
    assign do_push = push_valid & push_ready;
    assign do_pop = pop_valid & pop_ready;
    assign pop_data = mem[rd_q];
    assign count = cnt_q;

    always_ff @(posedge mclk)
    begin
        if (do_push)
        begin
            mem[wr_q] <= push_data;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (do_pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt_q <= '0;
        end
        else if (do_push && !do_pop)
        begin
            cnt_q <= cnt_q + 1'b1;
        end
        else if (do_pop && !do_push)
        begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule

// [verif/iru_ir_model.sv]
// Purpose: infrared transceiver stand-in for the serial port bench
// Assumes: same bit period in clocks as the port under test
// Notes: idle line high; frames heard with a high stop bit are logged in heard_q

`timescale 1ns/10ps

module iru_ir_model #(
    parameter int BIT_CYCLES = 16
)(
    input wire logic mclk,
    input wire logic ir_txd,
    output logic ir_rxd
);
    logic [7:0] heard_q[$];
    int bad_stops = 0;

    initial ir_rxd = 1'b1;

    // ----
    // listener
    // ----
    always
    begin : listen
        logic [7:0] b;
        @(negedge ir_txd);
        repeat (BIT_CYCLES / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYCLES) @(posedge mclk);
            b[i] = ir_txd;
        end
        repeat (BIT_CYCLES) @(posedge mclk);
        if (ir_txd === 1'b1) heard_q.push_back(b);
        else bad_stops++;
    end

    // ----
    // sender, called right after a clock edge
    // ----
    task automatic send(input logic [7:0] b, input logic stop, input int gap);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            ir_rxd <= f[i];
            repeat (BIT_CYCLES) @(posedge mclk);
        end
        // a bad stop is released to idle only after its full bit time
        ir_rxd <= 1'b1;
        repeat (gap) @(posedge mclk);
    endtask
endmodule

// [verif/iru_uart_test.sv]
// Purpose: self-checking bench for the infrared serial port
// Assumes: short bit period and queue depth to keep the run brief
// Notes: the transceiver stand-in drives ir_rxd and logs ir_txd

`timescale 1ns/10ps

module iru_uart_test;
    import iru_pkg::*;

    localparam int DEPTH = 34;
    localparam int BITC = 16;
    localparam logic [31:0] BAD_OFS = 32'hFF20_1030;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] avs_address = 32'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ir_rxd;
    logic ir_txd;
    logic irq;
    int mismatches = 0;
    int total_checks = 0;
    int n;
    logic [31:0] r;

    always #4 mclk = ~mclk;

    iru_uart #(.DEPTH(DEPTH), .BIT_CYCLES(BITC)) iru_uart_inst (
        .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .ir_rxd, .ir_txd, .irq
    );

    iru_ir_model #(.BIT_CYCLES(BITC)) iru_ir_model_inst (.mclk, .ir_txd, .ir_rxd);

    // ----
    // tasks
    // ----
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // holds the request until waitrequest is sampled low, then idles one cycle
    task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 40);
        if (avs_waitrequest !== 1'b0)
        begin
            mismatches++;
            $display("mismatch waitrequest expected 0 seen %b", avs_waitrequest);
            end_of_test();
        end
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [31:0] a);
        access(1'b0, a, 32'h0);
    endtask

    function automatic logic [31:0] dw(input logic [7:0] c, input logic v, input logic [7:0] ch);
        return {8'h00, c, v, 7'h00, ch};
    endfunction

    function automatic logic [31:0] cw(input logic [7:0] f, input logic tp, input logic rp,
        input logic [1:0] en);
        return {8'h00, f, 6'h00, tp, rp, 6'h00, en};
    endfunction

    // ----
    // sequence
    // ----
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check("txd idle", 32'h1, {31'h0, ir_txd});
        check("irq reset", 32'h0, {31'h0, irq});
        rd(CTRL_OFS);
        check("ctrl reset", cw(8'h22, 1'b1, 1'b0, 2'h0), r);
        rd(DATA_OFS);
        check("data empty", 32'h0, r);
        rd(BAD_OFS);
        check("unmapped read", 32'h0, r);
        access(1'b1, BAD_OFS, 32'hFFFF_FFFF);
        avs_byteenable <= 4'hE;
        access(1'b1, CTRL_OFS, 32'h3);
        avs_byteenable <= 4'hF;
        rd(CTRL_OFS);
        check("ctrl kept", cw(8'h22, 1'b1, 1'b0, 2'h0), r);
        rd(MASK_OFS);
        check("mask kept", 32'h0, r);
        $display("test reset done");

        iru_ir_model_inst.send(8'hA5, 1'b1, 2);
        access(1'b1, DATA_OFS, 32'h1234_565A);
        rd(DATA_OFS);
        check("rx one", dw(8'h00, 1'b1, 8'hA5), r);
        rd(DATA_OFS);
        check("rx empty", 32'h0, r);
        $display("test single done");

        access(1'b1, CTRL_OFS, 32'h1);
        // alternate gaps so the receiver meets both prompt and slow senders
        for (int i = 0; i <= DEPTH; i++)
            iru_ir_model_inst.send(8'h10 + 8'(i), 1'b1, (i % 2 == 0) ? 1 : 40);
        check("rx irq", 32'h1, {31'h0, irq});
        rd(CTRL_OFS);
        check("ctrl rx full", cw(8'h22, 1'b1, 1'b1, 2'h1), r);
        rd(STAT_OFS);
        check("rx overflow", 32'h1, r);
        for (int i = 0; i < DEPTH; i++)
        begin
            rd(DATA_OFS);
            check("rx char", dw(8'(DEPTH - 1 - i), 1'b1, 8'h10 + 8'(i)), r);
            if (DEPTH - 1 - i == 32 || DEPTH - 1 - i == 31)
                check("rx irq edge", {31'h0, DEPTH - 1 - i == 32}, {31'h0, irq});
        end
        rd(DATA_OFS);
        check("rx drained", 32'h0, r);
        access(1'b1, STAT_OFS, 32'h1);
        rd(STAT_OFS);
        check("status clear", 32'h0, r);
        access(1'b1, CTRL_OFS, 32'h0);
        access(1'b1, MASK_OFS, 32'h4);
        iru_ir_model_inst.send(8'h77, 1'b0, 4);
        check("frame irq", 32'h1, {31'h0, irq});
        rd(STAT_OFS);
        check("frame error", 32'h4, r);
        access(1'b1, STAT_OFS, 32'h4);
        check("irq cleared", 32'h0, {31'h0, irq});
        // a low stop bit is followed by a rise to idle, not a fall; nothing may be read as a new frame
        repeat (12 * BITC) @(posedge mclk);
        rd(DATA_OFS);
        check("no false frame", 32'h0, r);
        $display("test rx queue done");

        access(1'b1, CTRL_OFS, 32'h2);
        check("tx irq", 32'h1, {31'h0, irq});
        for (int i = 0; i < DEPTH + 2; i++)
            access(1'b1, DATA_OFS, {24'h0, 8'h40 + 8'(i)});
        rd(CTRL_OFS);
        check("tx space low", 32'h0, {24'h0, r[23:16]});
        check("tx irq off", 32'h0, {30'h0, r[9], irq});
        rd(STAT_OFS);
        check("tx drop", 32'h2, r);
        n = 0;
        do
        begin
            rd(CTRL_OFS);
            n++;
        end
        while (r[23:16] !== 8'h22 && n < 4000);
        check("tx drained", cw(8'h22, 1'b1, 1'b0, 2'h2), r);
        if (r[23:16] !== 8'h22)
            end_of_test();
        repeat (12 * BITC) @(posedge mclk);
        n = iru_ir_model_inst.heard_q.size();
        check("tx frames", 32'(DEPTH + 2), n);
        for (int i = 0; i < n; i++)
            check("tx char", {24'h0, i == 0 ? 8'h5A : 8'h40 + 8'(i - 1)},
                {24'h0, iru_ir_model_inst.heard_q[i]});
        check("stop bits", 32'h0, iru_ir_model_inst.bad_stops);
        $display("test tx queue done");
        end_of_test();
    end
endmodule
